// ==== test/rd_properties.sv ====
// rate divider checker on the link and the generator outputs
`timescale 1ns/1ps
`default_nettype none
`include "rd_cfg.svh"
module rd_properties (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic wr_en,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic rate_clk_out,
	input wire logic tx_mux_clk_out,
	input wire logic rx_mux_clk_out,
	input wire logic tx_clk_from_aux_in,
	input wire logic rx_clk_from_aux_in,
	input wire logic aux_clock_pin_oe_out,
	input wire logic running_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	logic [15:0] tc;
	logic src;
	logic sq_d;
	logic [16:0] cnt;
	wire misc_wr = wr_en && addr == `RD_REG_MISC;
	wire [16:0] tc2 = {1'b0, tc} + 17'h00002;
	// shadow of the link writes; cnt is cycles since start or last toggle
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			tc <= `RD_TC_RESET;
			src <= 1'b0;
		end else begin
			if (wr_en && addr == `RD_REG_TC_LOW)
				tc[7:0] <= wdata;
			if (wr_en && addr == `RD_REG_TC_HIGH)
				tc[15:8] <= wdata;
			if (misc_wr)
				src <= wdata[`RD_MISC_SRC_BIT];
		end
		sq_d <= rate_clk_out;
		cnt <= !running_out ? 17'h00000 : (rate_clk_out != sq_d ? 17'h00001 : cnt + 17'h00001);
	end
	chk_start_delay: assert property (misc_wr && wdata[0] && wdata[`RD_MISC_SRC_BIT] && !running_out |=> !running_out ##[1:2] running_out) else $error("start delay wrong");
	chk_src_stopped: assert property (misc_wr && wdata[`RD_MISC_SRC_BIT] != src |-> !running_out) else $error("source changed while on");
	chk_stop_now: assert property (misc_wr && !wdata[0] |=> !running_out) else $error("stop not immediate");
	chk_idle_high: assert property (!running_out && $past(!running_out) |-> rate_clk_out) else $error("stopped output low");
	chk_start_high: assert property ($rose(running_out) |-> rate_clk_out) else $error("start level low");
	chk_half_period: assert property (src && running_out && $past(running_out) && $changed(rate_clk_out) |-> cnt == tc2) else $error("half period wrong");
	chk_no_late: assert property (src && running_out |-> cnt <= tc2) else $error("toggle missing");
	chk_aux_free: assert property (aux_clock_pin_oe_out |-> $past(!tx_clk_from_aux_in && !rx_clk_from_aux_in)) else $error("aux pin driven");
	chk_mux_feed: assert property (tx_mux_clk_out == rate_clk_out && rx_mux_clk_out == rate_clk_out) else $error("mux clock differs");
	chk_stop_first: assert property (wr_en && addr == `RD_REG_TC_LOW |-> $past(misc_wr && !wdata[0])) else $error("tc written while on");
	chk_tc_order: assert property (wr_en && addr == `RD_REG_TC_HIGH |-> $past(wr_en && addr == `RD_REG_TC_LOW)) else $error("tc order wrong");
	cov_start: cover property ($rose(running_out));
	cov_toggle: cover property (src && $changed(rate_clk_out));
	cov_aux: cover property (aux_clock_pin_oe_out);
endmodule : rd_properties
`default_nettype wire

// ==== test/tb_top.sv ====
// rate divider bench: controller drives the divider over the link
`timescale 1ns/1ps
`default_nettype none
`include "rd_cfg.svh"
module tb_top;
	logic core_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [3:0] addr_in = 4'h0;
	logic [31:0] wdata_in = 32'h00000000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic rx_clock_pin_in = 1'b0;
	logic tx_clk_from_aux_in = 1'b0;
	logic rx_clk_from_aux_in = 1'b0;
	logic [31:0] rdata_out;
	logic busy_out, rate_clk_out, tx_mux_clk_out, rx_mux_clk_out, bit_tick_out;
	logic aux_clock_pin_out, aux_clock_pin_oe_out, running_out;
	logic [31:0] d;
	int n_errors = 0;
	int n_checks = 0;
	int n;
	rd_if link ();
	rd_host u_rd_host (.core_clk_in, .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .busy_out, .bus(link));
	rd_device u_rd_device (.core_clk_in, .srst_in, .bus(link), .rx_clock_pin_in,
		.tx_clk_from_aux_in, .rx_clk_from_aux_in, .rate_clk_out, .tx_mux_clk_out,
		.rx_mux_clk_out, .bit_tick_out, .aux_clock_pin_out, .aux_clock_pin_oe_out, .running_out);
	rd_properties u_rd_properties (.core_clk_in, .srst_in, .wr_en(link.wr_en),
		.addr(link.addr), .wdata(link.wdata), .rate_clk_out, .tx_mux_clk_out, .rx_mux_clk_out,
		.tx_clk_from_aux_in, .rx_clk_from_aux_in, .aux_clock_pin_oe_out, .running_out);
	// 200 MHz clock
	always #2.5 core_clk_in = ~core_clk_in;
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	// a bound that runs out is a mismatch and ends the run
	task ran_out;
		n_errors++;
		$display("unexpected at %0t: wait ran out", $time);
		final_report;
	endtask : ran_out
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask : chk
	// one-cycle strobes with a gap so no signal is driven twice in a step
	task wr_reg(input logic [3:0] a, input logic [31:0] v);
		@(posedge core_clk_in);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
		#1;
	endtask : wr_reg
	task rd_reg(input logic [3:0] a);
		@(posedge core_clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge core_clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask : rd_reg
	// sel 0: controller idle, sel 1: generator running
	task automatic wait_on(input int sel);
		int i;
		for (i = 0; i < 200 && (sel ? running_out !== 1'b1 : busy_out !== 1'b0); i++) begin
			@(posedge core_clk_in);
			#1;
		end
		if (sel ? running_out !== 1'b1 : busy_out !== 1'b0)
			ran_out;
	endtask : wait_on
	// cycles until the square wave next changes
	task automatic half(output int k);
		logic v;
		v = rate_clk_out;
		k = 0;
		while (k < 600 && rate_clk_out === v) begin
			@(posedge core_clk_in);
			#1 k++;
		end
		if (k >= 600)
			ran_out;
	endtask : half
	task automatic tick_gap(output int k);
		k = 0;
		while (k < 600 && bit_tick_out !== 1'b1) begin
			@(posedge core_clk_in);
			#1 k++;
		end
		if (k >= 600)
			ran_out;
		k = 0;
		do begin
			@(posedge core_clk_in);
			#1 k++;
		end while (k < 600 && bit_tick_out !== 1'b1);
		if (k >= 600)
			ran_out;
	endtask : tick_gap
	task t_reset;
		rd_reg(`RD_HOST_STAT);
		chk(d, 32'h00000000, "status after reset");
		chk(d[3], 1'b0, "source after reset");
		chk(running_out, 1'b0, "running after reset");
		rd_reg(4'hC);
		chk(d, 32'h00000000, "unmapped read");
		$display("reset test done");
	endtask : t_reset
	task automatic t_core(input logic [15:0] tc, input logic [1:0] r, input int mult);
		wr_reg(`RD_HOST_TC, {16'h0000, tc});
		wr_reg(`RD_HOST_CTRL, {28'h0000000, r, 2'b11});
		wait_on(0);
		wait_on(1);
		chk(rate_clk_out, 1'b1, "start level");
		half(n);
		half(n);
		chk(n, tc + 2, "half period");
		tick_gap(n);
		chk(n, 2 * mult * (tc + 2), "bit tick spacing");
		rd_reg(`RD_HOST_STAT);
		chk(d[9:2], 8'h03, "misc copy");
		$display("core source test done");
	endtask : t_core
	// tc write during the stop sequence is turned away
	task t_refuse;
		wr_reg(`RD_HOST_CTRL, 32'h00000007);
		wr_reg(`RD_HOST_TC, 32'h00000009);
		wait_on(0);
		rd_reg(`RD_HOST_STAT);
		chk(d[1], 1'b1, "refused flag");
		rd_reg(`RD_HOST_STAT);
		chk(d[1], 1'b0, "flag cleared");
		rd_reg(`RD_HOST_TC);
		chk(d, 32'h00000003, "refused constant dropped");
		rd_reg(`RD_HOST_CTRL);
		chk(d, 32'h00000007, "ctrl readback");
		wait_on(1);
		half(n);
		half(n);
		chk(n, 5, "old constant kept");
		$display("refuse test done");
	endtask : t_refuse
	task t_aux_stop;
		repeat (3) @(posedge core_clk_in);
		#1 chk(aux_clock_pin_oe_out, 1'b1, "aux pin free");
		chk(aux_clock_pin_out, rate_clk_out, "aux pin carries output");
		@(posedge core_clk_in);
		tx_clk_from_aux_in <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		#1 chk(aux_clock_pin_oe_out, 1'b0, "aux pin taken");
		@(posedge core_clk_in);
		tx_clk_from_aux_in <= 1'b0;
		wr_reg(`RD_HOST_CTRL, 32'h00000001);
		wait_on(0);
		chk(running_out, 1'b0, "stopped");
		chk(rate_clk_out, 1'b1, "stopped level");
		$display("aux and stop test done");
	endtask : t_aux_stop
	// reset while running: generator off, pin source, output high
	task t_midreset;
		wr_reg(`RD_HOST_CTRL, 32'h00000003);
		wait_on(0);
		wait_on(1);
		@(posedge core_clk_in);
		srst_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		srst_in <= 1'b0;
		#1 chk(running_out, 1'b0, "running after mid reset");
		chk(rate_clk_out, 1'b1, "level after mid reset");
		chk(aux_clock_pin_oe_out, 1'b0, "aux after mid reset");
		rd_reg(`RD_HOST_STAT);
		chk(d, 32'h00000000, "status after mid reset");
		$display("mid-run reset test done");
	endtask : t_midreset
	// pin source: square wave follows pin edges, stands still with the pin
	task automatic t_pin;
		logic v;
		int m;
		wr_reg(`RD_HOST_TC, 32'h00000000);
		wr_reg(`RD_HOST_CTRL, 32'h00000002);
		wait_on(0);
		v = rate_clk_out;
		n = 0;
		m = 0;
		// pin toggles for 320 cycles, then rests; changes counted per phase
		for (int i = 0; i < 920; i++) begin
			@(posedge core_clk_in);
			if (i % 4 == 0 && i < 320)
				rx_clock_pin_in <= ~rx_clock_pin_in;
			#1;
			if (rate_clk_out !== v && i < 320)
				n++;
			if (rate_clk_out !== v && i >= 320)
				m++;
			v = rate_clk_out;
		end
		chk(n > 15, 1'b1, "pin clocked toggles");
		chk(m, 0, "no toggle without pin");
		$display("pin source test done");
	endtask : t_pin
	initial begin
		repeat (16) @(posedge core_clk_in);
		srst_in <= 1'b0;
		@(posedge core_clk_in);
		t_reset;
		t_core(16'h0000, 2'h0, 1);
		t_core(16'h0000, 2'h1, 16);
		t_core(16'h0000, 2'h2, 32);
		t_core(16'h0000, 2'h3, 64);
		t_core(16'h0103, 2'h0, 1);
		t_core(16'h0003, 2'h1, 16);
		t_refuse;
		t_aux_stop;
		t_midreset;
		t_pin;
		final_report;
	end
endmodule : tb_top
`default_nettype wire

// ==== verilog/rd_cfg.svh ====
// rate divider register offsets, field positions and reset values
`ifndef RD_CFG_SVH
`define RD_CFG_SVH

// device write registers, index on the device write port
`define RD_REG_TC_LOW 2'h0
`define RD_REG_TC_HIGH 2'h1
`define RD_REG_MISC 2'h2
`define RD_REG_RATIO 2'h3

// misc_ctrl_reg fields
`define RD_MISC_EN_BIT 0
`define RD_MISC_SRC_BIT 1
`define RD_MISC_RESET 8'h00
`define RD_TC_RESET 16'h0000
`define RD_TC_BYTE_RESET 8'h00

// clock_ratio_reg field: two bits at D7..D6
`define RD_RATIO_LSB 6
`define RD_RATIO_RESET 2'h0

// square-wave periods per data bit, minus one
`define RD_DIV_X1 6'h00
`define RD_DIV_X16 6'h0F
`define RD_DIV_X32 6'h1F
`define RD_DIV_X64 6'h3F

// controller register byte offsets
`define RD_HOST_TC 4'h0
`define RD_HOST_CTRL 4'h4
`define RD_HOST_STAT 4'h8

// controller ctrl fields
`define RD_CTRL_SRC_BIT 0
`define RD_CTRL_EN_BIT 1
`define RD_CTRL_RATIO_LSB 2
`define RD_CTRL_RESET 4'h0

`endif

// ==== verilog/rd_device.sv ====
// rate divider: programmable baud rate generator of one serial channel
`timescale 1ns/1ps
`default_nettype none

`include "rd_cfg.svh"

module rd_device (
	input wire logic core_clk_in,
	input wire logic srst_in,
	rd_if.dev bus,
	input wire logic rx_clock_pin_in,
	input wire logic tx_clk_from_aux_in,
	input wire logic rx_clk_from_aux_in,
	output logic rate_clk_out,
	output logic tx_mux_clk_out,
	output logic rx_mux_clk_out,
	output logic bit_tick_out,
	output logic aux_clock_pin_out,
	output logic aux_clock_pin_oe_out,
	output logic running_out
);

	// write registers
	logic [7:0] tc_low_reg;
	logic [7:0] tc_high_reg;
	logic [7:0] misc_ctrl_reg;
	rd_pkg::rd_ratio_t clock_ratio_reg;

	// write decode
	wire wr_tc_low = bus.wr_en && (bus.addr == `RD_REG_TC_LOW);
	wire wr_tc_high = bus.wr_en && (bus.addr == `RD_REG_TC_HIGH);
	wire wr_misc = bus.wr_en && (bus.addr == `RD_REG_MISC);
	wire wr_ratio = bus.wr_en && (bus.addr == `RD_REG_RATIO);

	// register fields
	wire [15:0] tc_value = {tc_high_reg, tc_low_reg};
	wire en_bit = misc_ctrl_reg[`RD_MISC_EN_BIT];
	wire src_core = misc_ctrl_reg[`RD_MISC_SRC_BIT];

	// register writes; tc is taken raw, the counter only samples it at start and at reload
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			tc_low_reg <= `RD_TC_BYTE_RESET;
			tc_high_reg <= `RD_TC_BYTE_RESET;
			misc_ctrl_reg <= `RD_MISC_RESET;
			clock_ratio_reg <= rd_pkg::rd_ratio_t'(`RD_RATIO_RESET);
		end else begin
			if (wr_tc_low) begin
				tc_low_reg <= bus.wdata;
			end
			if (wr_tc_high) begin
				tc_high_reg <= bus.wdata;
			end
			if (wr_misc) begin
				misc_ctrl_reg <= bus.wdata;
			end
			if (wr_ratio) begin
				clock_ratio_reg <= rd_pkg::rd_ratio_t'(bus.wdata[`RD_RATIO_LSB +: 2]);
			end
		end
	end

	// rx pin comes from outside: two flip-flops, then a third for the edge
	logic pin_s1;
	logic pin_s2;
	logic pin_s3;
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_s3 <= 1'b0;
		end else begin
			pin_s1 <= rx_clock_pin_in;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// counter clock: one tick per rising pin edge or every core cycle
	wire pin_rise = pin_s2 && !pin_s3;
	wire gen_tick = src_core ? 1'b1 : pin_rise;

	// enable synchroniser stepped by the generator clock; clear is immediate
	logic en_s1;
	logic en_s2;
	always_ff @(posedge core_clk_in) begin
		if (srst_in || !en_bit) begin
			en_s1 <= 1'b0;
			en_s2 <= 1'b0;
		end else if (gen_tick) begin
			en_s1 <= 1'b1;
			en_s2 <= en_s1;
		end
	end

	// enable bit gates directly so a clear needs no generator edge
	wire running = en_bit && en_s2;
	logic running_q;
	wire start = running && !running_q;

	// down counter state
	logic [15:0] count;
	logic reload_pend;
	logic sq_out;
	wire at_zero = (count == 16'h0000);
	wire toggle_now = running && !start && gen_tick && !reload_pend && at_zero;
	wire rise_now = toggle_now && !sq_out;

	// counter: load tick, tc decrements, zero tick, so tc+2 ticks per half
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			running_q <= 1'b0;
			count <= `RD_TC_RESET;
			reload_pend <= 1'b0;
			sq_out <= 1'b1;
		end else begin
			running_q <= running;
			if (!running) begin
				reload_pend <= 1'b0;
				sq_out <= 1'b1;
			end else if (start) begin
				sq_out <= 1'b1;
				count <= tc_value;
				reload_pend <= 1'b0;
			end else if (gen_tick) begin
				if (reload_pend) begin
					count <= tc_value;
					reload_pend <= 1'b0;
				end else if (at_zero) begin
					sq_out <= !sq_out;
					reload_pend <= 1'b1;
				end else begin
					count <= count - 16'h0001;
				end
			end
		end
	end

	// square-wave periods per data bit from the clock mode
	logic [5:0] mode_last;
	always_comb begin
		unique case (clock_ratio_reg)
			rd_pkg::RD_X1: mode_last = `RD_DIV_X1;
			rd_pkg::RD_X16: mode_last = `RD_DIV_X16;
			rd_pkg::RD_X32: mode_last = `RD_DIV_X32;
			rd_pkg::RD_X64: mode_last = `RD_DIV_X64;
		endcase
	end

	// bit tick: one pulse per mode square-wave periods
	logic [5:0] mode_cnt;
	logic bit_tick;
	wire mode_wrap = (mode_cnt >= mode_last);
	always_ff @(posedge core_clk_in) begin
		if (srst_in || !running) begin
			mode_cnt <= 6'h00;
			bit_tick <= 1'b0;
		end else begin
			bit_tick <= rise_now && mode_wrap;
			if (rise_now) begin
				mode_cnt <= mode_wrap ? 6'h00 : mode_cnt + 6'h01;
			end
		end
	end

	// aux pin only when neither channel clock is taken from it
	wire aux_free = !tx_clk_from_aux_in && !rx_clk_from_aux_in;
	logic aux_oe;
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			aux_oe <= 1'b0;
		end else begin
			aux_oe <= aux_free && running;
		end
	end

	// outputs; the square wave feeds both channel clock muxes
	assign rate_clk_out = sq_out;
	assign tx_mux_clk_out = sq_out;
	assign rx_mux_clk_out = sq_out;
	assign bit_tick_out = bit_tick;
	assign aux_clock_pin_out = sq_out;
	assign aux_clock_pin_oe_out = aux_oe;
	assign running_out = running;

endmodule : rd_device

`default_nettype wire

// ==== verilog/rd_host.sv ====
// rate divider controller: runs the stop/load/select/enable sequence
`timescale 1ns/1ps
`default_nettype none

`include "rd_cfg.svh"

module rd_host (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic busy_out,
	rd_if.host bus
);

	rd_pkg::rd_host_state_t state;
	rd_pkg::rd_host_state_t next_state;
	logic [15:0] tc;
	logic [3:0] ctrl;
	logic [7:0] misc_cur;
	logic refused;

	// user port decode
	wire wr_tc = wr_in && (addr_in == `RD_HOST_TC);
	wire wr_ctrl = wr_in && (addr_in == `RD_HOST_CTRL);
	wire idle = (state == rd_pkg::RD_IDLE);

	// requested settings
	wire src_new = ctrl[`RD_CTRL_SRC_BIT];
	wire en_new = ctrl[`RD_CTRL_EN_BIT];
	wire [1:0] ratio_new = ctrl[`RD_CTRL_RATIO_LSB +: 2];

	// user registers; tc and ctrl are locked while a sequence runs
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			tc <= `RD_TC_RESET;
			ctrl <= `RD_CTRL_RESET;
			refused <= 1'b0;
		end else begin
			if (wr_tc && idle) begin
				tc <= wdata_in[15:0];
			end
			if (wr_ctrl && idle) begin
				ctrl <= wdata_in[3:0];
			end
			if ((wr_tc || wr_ctrl) && !idle) begin
				refused <= 1'b1;
			end else if (rd_in && addr_in == `RD_HOST_STAT) begin
				refused <= 1'b0;
			end
		end
	end

	// sequence: stop first, so tc and source change only while stopped
	always_comb begin
		unique case (state)
			rd_pkg::RD_IDLE: next_state = wr_ctrl ? rd_pkg::RD_STOP : rd_pkg::RD_IDLE;
			rd_pkg::RD_STOP: next_state = rd_pkg::RD_TCL;
			rd_pkg::RD_TCL: next_state = rd_pkg::RD_TCH;
			rd_pkg::RD_TCH: next_state = rd_pkg::RD_RATIO;
			rd_pkg::RD_RATIO: next_state = rd_pkg::RD_SRC;
			rd_pkg::RD_SRC: next_state = rd_pkg::RD_ENA;
			rd_pkg::RD_ENA: next_state = rd_pkg::RD_IDLE;
			default: next_state = rd_pkg::RD_IDLE;
		endcase
	end

	// device write chosen by state; driven from flip-flops next cycle
	logic next_wr;
	logic [1:0] next_addr;
	logic [7:0] next_wdata;
	always_comb begin
		next_wr = !idle;
		next_addr = `RD_REG_MISC;
		next_wdata = misc_cur;
		unique case (state)
			rd_pkg::RD_IDLE: next_wdata = misc_cur;
			rd_pkg::RD_STOP: next_wdata = {misc_cur[7:1], 1'b0};
			rd_pkg::RD_TCL: begin
				next_addr = `RD_REG_TC_LOW;
				next_wdata = tc[7:0];
			end
			rd_pkg::RD_TCH: begin
				next_addr = `RD_REG_TC_HIGH;
				next_wdata = tc[15:8];
			end
			rd_pkg::RD_RATIO: begin
				next_addr = `RD_REG_RATIO;
				next_wdata = {ratio_new, 6'h00};
			end
			rd_pkg::RD_SRC: next_wdata = {6'h00, src_new, 1'b0};
			rd_pkg::RD_ENA: next_wdata = {6'h00, src_new, en_new};
			default: next_wr = 1'b0;
		endcase
	end

	// state, bus drive and a copy of what misc holds in the device
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			state <= rd_pkg::RD_IDLE;
			bus.wr_en <= 1'b0;
			bus.addr <= 2'h0;
			bus.wdata <= 8'h00;
			misc_cur <= `RD_MISC_RESET;
		end else begin
			state <= next_state;
			bus.wr_en <= next_wr;
			bus.addr <= next_addr;
			bus.wdata <= next_wdata;
			if (next_wr && next_addr == `RD_REG_MISC) begin
				misc_cur <= next_wdata;
			end
		end
	end

	// read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge core_clk_in) begin
		if (srst_in || !rd_in) begin
			rdata_out <= 32'h00000000;
		end else if (addr_in == `RD_HOST_TC) begin
			rdata_out <= {16'h0000, tc};
		end else if (addr_in == `RD_HOST_CTRL) begin
			rdata_out <= {28'h0000000, ctrl};
		end else if (addr_in == `RD_HOST_STAT) begin
			rdata_out <= {22'h000000, misc_cur, refused, !idle};
		end else begin
			rdata_out <= 32'h00000000;
		end
	end

	assign busy_out = !idle;

endmodule : rd_host

`default_nettype wire

// ==== verilog/rd_if.sv ====
// rate divider register write link between controller and divider
`timescale 1ns/1ps
`default_nettype none

interface rd_if;
	logic wr_en;
	logic [1:0] addr;
	logic [7:0] wdata;

	modport dev (input wr_en, input addr, input wdata);
	modport host (output wr_en, output addr, output wdata);
endinterface : rd_if

`default_nettype wire

// ==== verilog/rd_pkg.sv ====
// rate divider shared types
`default_nettype none

package rd_pkg;

	// clock mode: receive clock to data rate ratio
	typedef enum logic [1:0] {
		RD_X1 = 2'b00,
		RD_X16 = 2'b01,
		RD_X32 = 2'b10,
		RD_X64 = 2'b11
	} rd_ratio_t;

	// controller sequencer states
	typedef enum logic [2:0] {
		RD_IDLE = 3'b000,
		RD_STOP = 3'b001,
		RD_TCL = 3'b010,
		RD_TCH = 3'b011,
		RD_RATIO = 3'b100,
		RD_SRC = 3'b101,
		RD_ENA = 3'b110
	} rd_host_state_t;

endpackage : rd_pkg

`default_nettype wire
